/* gpio_port_pkg.sv */
// Package with register map, field positions and types for the port block
`default_nettype none
package gpio_port_pkg;
  localparam int unsigned PINS = 8;
  localparam int unsigned AW   = 4;
  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFS_DIRECTION = 4'h0;
  localparam logic [3:0] OFS_OUTPUT    = 4'h4;
  localparam logic [3:0] OFS_INPUT     = 4'h8;
  localparam logic [3:0] OFS_CONTROL   = 4'hC;
  // ---------------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned CTL_PUD_BIT  = 0;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_OUTPUT    = 8'h00;
  localparam logic       RST_PUD       = 1'h0;
  localparam logic [31:0] RD_UNMAPPED  = 32'h00000000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  // Per-port alternate function override set
  typedef struct packed {
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] dir_override_enable;
    logic [7:0] dir_override_value;
    logic [7:0] val_override_enable;
    logic [7:0] val_override_value;
    logic [7:0] din_override_enable;
    logic [7:0] din_override_value;
  } pin_override_t;
endpackage : gpio_port_pkg
`default_nettype wire

/* general_digital_io_port.sv */
// One eight-pin general purpose digital port with Avalon-MM register access
`default_nettype none
// Operation
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with latch one gets pull-up unless globally disabled.
// - Pull-up off when latch is zero or pin is an output.
// - Reset tri-states every pin.
// - Output pin drives latch value onto the pad.
// - Writing one to input bit toggles the latch; zero does nothing.
// - Global pull-up disable keeps every pull-up off except on pins with pull-up override enabled.
// - Input bit shows synchronized pad level in any direction.
// - Pad level passes a first stage, then loads the input bit.
// - External pad change reaches input bit after a short synchronizer delay.
// - Software-set pin value reaches input bit two clocks after the pad changes.
// - Sleep clamp forces digital inputs to ground in deep sleep.
// - Clamp skipped on pins with external interrupt enabled.
// - Clamp release on a high pad flags a change for interrupt logic.
// - Pull-ups held off throughout reset.
// - Strobes shared per port; clock, clamp, pull-up disable shared by all.
// - Alternate functions may override pin control signals.
// - Input register read-only; output and direction registers read-write.
// - Pull-up follows override value when enabled, else 0b010 decode.
module general_digital_io_port (
  input  wire logic                        i_clk,
  input  wire logic                        i_srst,
  input  wire logic [3:0]                  i_address,
  input  wire logic                        i_read,
  input  wire logic                        i_write,
  input  wire logic [31:0]                 i_writedata,
  input  wire logic [3:0]                  i_byteenable,
  output var  logic [31:0]                 o_readdata,
  output var  logic                        o_waitrequest,
  input  wire logic [7:0]                  i_pad,
  output var  logic [7:0]                  o_pad,
  output var  logic [7:0]                  o_pad_oe,
  output var  logic [7:0]                  o_pullup_en,
  input  wire logic                        i_sleep,
  input  wire logic [7:0]                  i_ext_int_en,
  input  wire gpio_port_pkg::pin_override_t i_ovr,
  output var  logic [7:0]                  o_din,
  output var  logic [7:0]                  o_clamp_release_change
);
  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  gpio_port_pkg::bus_state_t bus_r;
  logic [7:0]  dir_r;
  logic [7:0]  latch_r;
  logic        pud_r;
  logic [7:0]  sync_stage_r;
  logic [7:0]  pin_in_r;
  logic [7:0]  clamp_r;
  logic [31:0] rdata_nxt;

  wire        req        = (i_read | i_write) & (bus_r == gpio_port_pkg::BUS_IDLE);
  wire        commit     = i_write & (bus_r == gpio_port_pkg::BUS_ACK);
  wire        lane0      = i_byteenable[0];
  wire        sel_dir    = (i_address == gpio_port_pkg::OFS_DIRECTION);
  wire        sel_out    = (i_address == gpio_port_pkg::OFS_OUTPUT);
  wire        sel_in     = (i_address == gpio_port_pkg::OFS_INPUT);
  wire        sel_ctl    = (i_address == gpio_port_pkg::OFS_CONTROL);
  // Shared strobes for all eight pins of the port
  wire        wr_dir     = commit & lane0 & sel_dir;
  wire        wr_out     = commit & lane0 & sel_out;
  wire        wr_in      = commit & lane0 & sel_in;
  wire        wr_ctl     = commit & lane0 & sel_ctl;
  wire [7:0]  wdat       = i_writedata[7:0];

  always_comb begin
    if (sel_dir) begin
      rdata_nxt = {24'h000000, dir_r};
    end else if (sel_out) begin
      rdata_nxt = {24'h000000, latch_r};
    end else if (sel_in) begin
      rdata_nxt = {24'h000000, pin_in_r};
    end else if (sel_ctl) begin
      rdata_nxt = {31'h00000000, pud_r};
    end else begin
      rdata_nxt = gpio_port_pkg::RD_UNMAPPED;
    end
  end

  // ---------------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------------
  // Toggle through the input address; input register itself keeps nothing
  wire [7:0] latch_toggled = latch_r ^ wdat;
  wire [7:0] latch_nxt     = wr_out ? wdat : (wr_in ? latch_toggled : latch_r);
  wire [7:0] dir_nxt       = wr_dir ? wdat : dir_r;
  wire       pud_nxt       = wr_ctl ? wdat[gpio_port_pkg::CTL_PUD_BIT] : pud_r;

  // ---------------------------------------------------------------------
  // Pin control with alternate function overrides
  // ---------------------------------------------------------------------
  wire [7:0] eff_dir = (i_ovr.dir_override_enable & i_ovr.dir_override_value)
                     | (~i_ovr.dir_override_enable & dir_nxt);
  wire [7:0] eff_val = (i_ovr.val_override_enable & i_ovr.val_override_value)
                     | (~i_ovr.val_override_enable & latch_nxt);
  // Pull-up on only for {dir, latch, pud} = 0b010 unless overridden
  wire [7:0] pu_gp   = ~dir_nxt & latch_nxt & {8{~pud_nxt}};
  wire [7:0] pu_nxt  = (i_ovr.pullup_override_enable & i_ovr.pullup_override_value)
                     | (~i_ovr.pullup_override_enable & pu_gp);
  // Digital input enable: sleep clamp unless ext interrupt or override
  wire [7:0] din_en  = (i_ovr.din_override_enable & i_ovr.din_override_value)
                     | (~i_ovr.din_override_enable
                        & ~({8{i_sleep}} & ~i_ext_int_en));
  wire [7:0] clamp_nxt = ~din_en;
  // Only the second synchronizer stage feeds the peripherals
  wire [7:0] clamped   = pin_in_r & din_en;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bus_r         <= gpio_port_pkg::BUS_IDLE;
      o_waitrequest <= 1'b1;
      o_readdata    <= gpio_port_pkg::RD_UNMAPPED;
    end else begin
      bus_r         <= req ? gpio_port_pkg::BUS_ACK : gpio_port_pkg::BUS_IDLE;
      o_waitrequest <= ~req;
      o_readdata    <= rdata_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dir_r   <= gpio_port_pkg::RST_DIRECTION;
      latch_r <= gpio_port_pkg::RST_OUTPUT;
      pud_r   <= gpio_port_pkg::RST_PUD;
    end else begin
      dir_r   <= dir_nxt;
      latch_r <= latch_nxt;
      pud_r   <= pud_nxt;
    end
  end

  // Pad drivers: tri-state and pull-ups off while reset is held
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pad_oe    <= 8'h00;
      o_pad       <= 8'h00;
      o_pullup_en <= 8'h00;
    end else begin
      o_pad_oe    <= eff_dir;
      o_pad       <= eff_val;
      o_pullup_en <= pu_nxt;
    end
  end

  // Two-stage synchronizer; first stage read only by the second
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync_stage_r <= 8'h00;
      pin_in_r     <= 8'h00;
    end else begin
      sync_stage_r <= i_pad;
      pin_in_r     <= sync_stage_r;
    end
  end

  // Clamped digital input to peripherals and change on clamp release
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clamp_r                <= 8'h00;
      o_din                  <= 8'h00;
      o_clamp_release_change <= 8'h00;
    end else begin
      clamp_r                <= clamp_nxt;
      o_din                  <= clamped;
      o_clamp_release_change <= clamp_r & ~clamp_nxt & pin_in_r;
    end
  end
endmodule : general_digital_io_port
`default_nettype wire

/* gpio_port_chk.sv */
// Assertions on the pins and bus of the port block
`default_nettype none
module gpio_port_chk (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [3:0]  i_address,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic        o_waitrequest,
  input wire logic [7:0]  i_pad,
  input wire logic [7:0]  o_pad,
  input wire logic [7:0]  o_pad_oe,
  input wire logic [7:0]  o_pullup_en,
  input wire logic        i_sleep,
  input wire logic [7:0]  i_ext_int_en,
  input wire logic [7:0]  o_din,
  input wire logic [7:0]  o_clamp_release_change
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire logic       wr     = i_write && !o_waitrequest;
  wire logic [7:0] wd     = i_writedata[7:0];
  wire logic       wr_dir = wr && i_address == gpio_port_pkg::OFS_DIRECTION;
  wire logic       wr_in  = wr && i_address == gpio_port_pkg::OFS_INPUT;
  wire logic       wr_ctl = wr && i_address == gpio_port_pkg::OFS_CONTROL;
  chk_reset_tristate: assert property ($past(i_srst) |-> (o_pad_oe | o_pullup_en) == 8'h00)
    else $error("pins active after reset");
  chk_dir_write: assert property (wr_dir |=> o_pad_oe == $past(wd))
    else $error("drive enable not from direction");
  chk_toggle_latch: assert property (wr_in |=> ((o_pad ^ $past(o_pad)) & o_pad_oe) == ($past(wd) & o_pad_oe))
    else $error("latch not toggled");
  chk_pullup_output: assert property ((o_pullup_en & o_pad_oe) == 8'h00)
    else $error("pull-up on driven pin");
  chk_pud_global: assert property (wr_ctl && wd[0] |=> o_pullup_en == 8'h00)
    else $error("pull-up despite disable");
  chk_sync_delay: assert property ((!i_sleep && !i_srst) [*4] |-> o_din == $past(i_pad, 3))
    else $error("input not synchronized");
  chk_sleep_clamp: assert property (i_sleep [*4] |-> (o_din & ~i_ext_int_en) == 8'h00)
    else $error("input not clamped");
  chk_release_pulse: assert property (o_clamp_release_change != 8'h00
    |=> (o_clamp_release_change & $past(o_clamp_release_change)) == 8'h00)
    else $error("release change not a pulse");
endmodule : gpio_port_chk
bind general_digital_io_port gpio_port_chk u_chk (.*);
`default_nettype wire

/* pad_env.sv */
// Model of the circuitry on the port pads
`default_nettype none
module pad_env (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_drive,
  input  wire logic [7:0] i_drive_oe,
  input  wire logic [7:0] i_pullup_en,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_oe,
  output var  logic [7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // A pin nobody drives or pulls wanders every cycle
  always_ff @(posedge i_clk) begin
    o_level <= (i_drive_oe & i_drive) | (~i_drive_oe & i_ext_oe & i_ext_val)
      | (~i_drive_oe & ~i_ext_oe & (i_pullup_en | ~o_level));
  end
endmodule : pad_env
`default_nettype wire

/* general_digital_io_port_tb_top.sv */
// Testbench for the port block
`default_nettype none
module general_digital_io_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_read = 1'b0, i_write = 1'b0, i_sleep = 1'b0;
  logic [3:0]  i_address = 4'h0, i_byteenable = 4'hF;
  logic [31:0] i_writedata = 32'h00000000, o_readdata;
  logic        o_waitrequest;
  logic [7:0]  i_pad, o_pad, o_pad_oe, o_pullup_en, o_din, o_clamp_release_change;
  logic [7:0]  i_ext_int_en = 8'h00, ext_val = 8'hA5, ext_oe = 8'hFF;
  gpio_port_pkg::pin_override_t i_ovr = '0;
  int          fails = 0, tests_run = 0;
  always #50 i_clk = ~i_clk;
  general_digital_io_port dut (
    .i_clk                  (i_clk),
    .i_srst                 (i_srst),
    .i_address              (i_address),
    .i_read                 (i_read),
    .i_write                (i_write),
    .i_writedata            (i_writedata),
    .i_byteenable           (i_byteenable),
    .o_readdata             (o_readdata),
    .o_waitrequest          (o_waitrequest),
    .i_pad                  (i_pad),
    .o_pad                  (o_pad),
    .o_pad_oe               (o_pad_oe),
    .o_pullup_en            (o_pullup_en),
    .i_sleep                (i_sleep),
    .i_ext_int_en           (i_ext_int_en),
    .i_ovr                  (i_ovr),
    .o_din                  (o_din),
    .o_clamp_release_change (o_clamp_release_change)
  );
  pad_env far (.i_clk(i_clk), .i_drive(o_pad), .i_drive_oe(o_pad_oe), .i_pullup_en(o_pullup_en),
    .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(i_pad));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_read <= rd;
    i_write <= !rd;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (rd) chk("readdata", o_readdata, {24'h000000, d});
  endtask : bus
  task automatic end_sim;
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    end_sim;
  end
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    chk("oe_pu", o_pad_oe | o_pullup_en, 8'h00);
    // Let the pad level pass both synchronizer stages first
    repeat (2) @(posedge i_clk);
    bus(1'b1, gpio_port_pkg::OFS_INPUT, 8'hA5);
    ext_oe <= 8'h0F;
    bus(1'b0, gpio_port_pkg::OFS_DIRECTION, 8'hF0);
    bus(1'b0, gpio_port_pkg::OFS_OUTPUT, 8'h3C);
    repeat (3) @(posedge i_clk);
    chk("oe", o_pad_oe, 8'hF0);
    chk("pad", o_pad & o_pad_oe, 8'h30);
    chk("pu", o_pullup_en, 8'h0C);
    bus(1'b1, gpio_port_pkg::OFS_INPUT, 8'h35);
    bus(1'b0, gpio_port_pkg::OFS_INPUT, 8'h81);
    bus(1'b0, 4'h2, 8'hFF);
    bus(1'b1, 4'h2, 8'h00);
    bus(1'b1, gpio_port_pkg::OFS_OUTPUT, 8'hBD);
    bus(1'b1, gpio_port_pkg::OFS_DIRECTION, 8'hF0);
    chk("pu", o_pullup_en, 8'h0D);
    bus(1'b0, gpio_port_pkg::OFS_CONTROL, 8'h01);
    @(posedge i_clk);
    chk("pu", o_pullup_en, 8'h00);
    i_ovr.pullup_override_enable <= 8'h03;
    i_ovr.pullup_override_value <= 8'h01;
    repeat (2) @(posedge i_clk);
    chk("pu_ovr", o_pullup_en, 8'h01);
    i_ovr <= '0;
    bus(1'b1, gpio_port_pkg::OFS_INPUT, 8'hB5);
    i_ext_int_en <= 8'h01;
    i_sleep <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("din", o_din, 8'h01);
    i_sleep <= 1'b0;
    for (int k = 0; k < 8 && o_clamp_release_change === 8'h00; k++) @(posedge i_clk);
    chk("release", o_clamp_release_change, 8'hB4);
    // Pins 2 and 3 go from input with pull-up disabled to driven low through driven high
    bus(1'b0, gpio_port_pkg::OFS_DIRECTION, 8'hFC);
    bus(1'b0, gpio_port_pkg::OFS_OUTPUT, 8'hB1);
    @(posedge i_clk);
    chk("oe", o_pad_oe, 8'hFC);
    chk("pad", o_pad & o_pad_oe, 8'hB0);
    // A write without lane 0 leaves the latch alone
    i_byteenable <= 4'hE;
    bus(1'b0, gpio_port_pkg::OFS_OUTPUT, 8'h00);
    i_byteenable <= 4'hF;
    bus(1'b1, gpio_port_pkg::OFS_OUTPUT, 8'hB1);
    // Reset again in mid-run
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("oe_pu", o_pad_oe | o_pullup_en, 8'h00);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_clk);
    bus(1'b1, gpio_port_pkg::OFS_DIRECTION, gpio_port_pkg::RST_DIRECTION);
    bus(1'b1, gpio_port_pkg::OFS_OUTPUT, gpio_port_pkg::RST_OUTPUT);
    end_sim;
  end
endmodule : general_digital_io_port_tb_top
`default_nettype wire
